// ---- src/aux_timer_capture_reload.sv ----
`timescale 1ns/100ps

// How it works
// - aux mode 00 timer, 01 counter, 10 gated low, 11 gated high
// - aux timer counts only while its run bit is one
// - aux timer and gated modes use the core timer logic unchanged
// - timer tick every 4 times 2 to the select clocks, 4 to 512
// - gated modes advance only with run set and gate at active level
// - aux timer has no toggle latch and no output pin
// - aux direction from direction bit and external enable like core
// - ext enable off: bit picks; on: pin level xor direction bit
// - counter select X00 off, 0xx count pin edges, 1xx toggle latch edges
// - only wrap driven toggle latch changes clock the aux counter
// - both latch edges give 32 bits, one edge gives 33 bits
// - chained timers keep own directions, core in any mode
// - capture edge 00 none, 01 rising, 10 falling, 11 either
// - selected capture edge copies aux value and sets capture flag
// - clear on capture zeroes aux timer after its value is latched
// - capture enable gates only latching; flag and clear still act
// - reload enable loads capture register into core on wrap
// - reload leaves capture flag alone, core flag still set
// - capture and reload may be enabled together independently
// - core underflow sets core flag and toggles the toggle latch
module aux_timer_capture_reload
  import aux_timer_pkg::*;
(
  // clock and reset
  input  wire logic                         aclk,
  input  wire logic                         aresetn,
  // write address channel
  input  wire logic                         s_axi_awvalid,
  output logic                              s_axi_awready,
  input  wire logic [aux_timer_pkg::ADDR_W-1:0] s_axi_awaddr,
  input  wire logic [2:0]                   s_axi_awprot,
  // write data channel
  input  wire logic                         s_axi_wvalid,
  output logic                              s_axi_wready,
  input  wire logic [aux_timer_pkg::DATA_W-1:0] s_axi_wdata,
  input  wire logic [3:0]                   s_axi_wstrb,
  // write response channel
  output logic                              s_axi_bvalid,
  input  wire logic                         s_axi_bready,
  output logic [1:0]                        s_axi_bresp,
  // read address channel
  input  wire logic                         s_axi_arvalid,
  output logic                              s_axi_arready,
  input  wire logic [aux_timer_pkg::ADDR_W-1:0] s_axi_araddr,
  input  wire logic [2:0]                   s_axi_arprot,
  // read data channel
  output logic                              s_axi_rvalid,
  input  wire logic                         s_axi_rready,
  output logic [aux_timer_pkg::DATA_W-1:0]  s_axi_rdata,
  output logic [1:0]                        s_axi_rresp,
  // external pins
  input  wire logic                         core_count_pin,
  input  wire logic                         core_dir_pin,
  input  wire logic                         aux_count_pin,
  input  wire logic                         aux_dir_pin,
  input  wire logic                         capture_input_pin,
  // request flags and latch state
  output logic                              core_irq_flag,
  output logic                              aux_irq_flag,
  output logic                              capture_irq_flag,
  output logic                              core_toggle_latch
);
  import aux_timer_pkg::*;

  // ----------------------------------------------------------------
  // helper functions
  // ----------------------------------------------------------------
  function automatic reg_sel_type decode(input logic [ADDR_W-1:0] addr);
    logic [IDX_W-1:0] idx;
    idx = addr[ADDR_W-1:2];
    decode = SEL_NONE;
    if (addr[1:0] == 2'h0) begin
      unique case (idx)
        AUX_CTRL_IDX:  decode = SEL_AUX_CTRL;
        CORE_CTRL_IDX: decode = SEL_CORE_CTRL;
        AUX_VAL_IDX:   decode = SEL_AUX_VAL;
        CORE_VAL_IDX:  decode = SEL_CORE_VAL;
        CAPTURE_RELOAD_REG_IDX:    decode = SEL_CAPTURE_RELOAD_REG;
        FLAGS_IDX:     decode = SEL_FLAGS;
        default:       decode = SEL_NONE;
      endcase
    end
  endfunction

  function automatic logic [REG_W-1:0] merge(input logic [REG_W-1:0] old,
                                             input logic [DATA_W-1:0] data,
                                             input logic [3:0] strb);
    merge = old;
    if (strb[0]) begin
      merge[7:0] = data[7:0];
    end
    if (strb[1]) begin
      merge[15:8] = data[15:8];
    end
  endfunction

  // two-bit edge code: 00 none, 01 rising, 10 falling, 11 either
  function automatic logic edge_pick(input logic [1:0] code,
                                     input logic rise,
                                     input logic fall);
    edge_pick = (code[0] & rise) | (code[1] & fall);
  endfunction

  function automatic logic pre_tick(input logic [PRE_W-1:0] cnt,
                                    input logic [2:0] sel);
    logic [PRE_W-1:0] mask;
    mask = PRE_W'((1 << (PRE_BASE_LOG2 + int'(sel))) - 1);
    pre_tick = ((cnt & mask) == mask);
  endfunction

  function automatic logic step(input mode_type mode,
                                input logic run,
                                input logic tick,
                                input logic gate,
                                input logic cnt_event);
    step = 1'b0;
    unique case (mode)
      MODE_TIMER:      step = run & tick;
      MODE_COUNTER:    step = run & cnt_event;
      MODE_GATED_LOW:  step = run & tick & ~gate;
      MODE_GATED_HIGH: step = run & tick & gate;
    endcase
  endfunction

  function automatic logic count_down(input logic ext_en,
                                      input logic dir_bit,
                                      input logic pin);
    count_down = ext_en ? (pin ^ dir_bit) : dir_bit;
  endfunction

  // ----------------------------------------------------------------
  // pin synchronisers and edge detection
  // ----------------------------------------------------------------
  logic [PIN_N-1:0] pins;
  logic [PIN_N-1:0] sync1_q;
  logic [PIN_N-1:0] sync2_q;
  logic [PIN_N-1:0] sync3_q;
  logic [PIN_N-1:0] level_q;
  logic [PIN_N-1:0] rise_q;
  logic [PIN_N-1:0] fall_q;

  assign pins = {capture_input_pin, aux_dir_pin, aux_count_pin, core_dir_pin,
                 core_count_pin};

  genvar gi;
  generate
    for (gi = 0; gi < PIN_N; gi++) begin : g_pin
      always_ff @(posedge aclk) begin
        if (!aresetn) begin
          sync1_q[gi] <= 1'b0;
          sync2_q[gi] <= 1'b0;
          sync3_q[gi] <= 1'b0;
          level_q[gi] <= 1'b0;
          rise_q[gi]  <= 1'b0;
          fall_q[gi]  <= 1'b0;
        end else begin
          sync1_q[gi] <= pins[gi];
          sync2_q[gi] <= sync1_q[gi];
          sync3_q[gi] <= sync2_q[gi];
          if (sync2_q[gi] == sync3_q[gi]) begin
            level_q[gi] <= sync3_q[gi];
          end
          rise_q[gi] <= (sync2_q[gi] == sync3_q[gi]) & sync3_q[gi] & ~level_q[gi];
          fall_q[gi] <= (sync2_q[gi] == sync3_q[gi]) & ~sync3_q[gi] & level_q[gi];
        end
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // registers and bus state
  // ----------------------------------------------------------------
  aux_ctrl_type       aux_ctrl_q;
  core_ctrl_type      core_ctrl_q;
  logic [REG_W-1:0]   aux_val_q;
  logic [REG_W-1:0]   core_val_q;
  logic [REG_W-1:0]   capture_reload_reg_q;
  logic [FLAG_N-1:0]  flags_q;
  logic [PRE_W-1:0]   pre_q;
  logic               aw_held_q;
  logic               w_held_q;
  logic [ADDR_W-1:0]  aw_addr_q;
  logic [DATA_W-1:0]  w_data_q;
  logic [3:0]         w_strb_q;
  logic               do_write;
  reg_sel_type        wsel;
  reg_sel_type        rsel;

  assign do_write = aw_held_q & w_held_q & ~s_axi_bvalid;
  assign wsel     = decode(aw_addr_q);
  assign rsel     = decode(s_axi_araddr);

  // ----------------------------------------------------------------
  // counting events
  // ----------------------------------------------------------------
  logic core_step;
  logic core_down;
  logic core_wrap;
  logic aux_step;
  logic aux_down;
  logic aux_wrap;
  logic aux_event;
  logic tl_rise;
  logic tl_fall;
  logic cap_event;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pre_q <= '0;
    end else begin
      pre_q <= pre_q + 1'b1;
    end
  end

  assign core_down = count_down(core_ctrl_q.core_ext_dir_enable, core_ctrl_q.core_dir_bit,
                                level_q[PIN_CORE_DIR]);
  assign aux_down  = count_down(aux_ctrl_q.aux_ext_dir_enable, aux_ctrl_q.aux_dir_bit,
                                level_q[PIN_AUX_DIR]);

  assign core_step = step(core_ctrl_q.core_mode_field, core_ctrl_q.core_run_bit,
                          pre_tick(pre_q, core_ctrl_q.core_input_select),
                          level_q[PIN_CORE_IN],
                          ~core_ctrl_q.core_input_select[2] &
                          edge_pick(core_ctrl_q.core_input_select[1:0],
                                    rise_q[PIN_CORE_IN], fall_q[PIN_CORE_IN]));
  assign core_wrap = core_step & (core_down ? (core_val_q == VAL_ZERO)
                                            : (core_val_q == VAL_MAX));

  // latch edges only from core wraps
  assign tl_rise = core_wrap & ~core_ctrl_q.core_toggle_latch;
  assign tl_fall = core_wrap & core_ctrl_q.core_toggle_latch;

  assign aux_event = aux_ctrl_q.aux_input_select[2]
                   ? edge_pick(aux_ctrl_q.aux_input_select[1:0], tl_rise, tl_fall)
                   : edge_pick(aux_ctrl_q.aux_input_select[1:0],
                               rise_q[PIN_AUX_IN], fall_q[PIN_AUX_IN]);

  assign aux_step = step(aux_ctrl_q.aux_mode_field, aux_ctrl_q.aux_run_bit,
                         pre_tick(pre_q, aux_ctrl_q.aux_input_select),
                         level_q[PIN_AUX_IN], aux_event);
  assign aux_wrap = aux_step & (aux_down ? (aux_val_q == VAL_ZERO)
                                         : (aux_val_q == VAL_MAX));

  assign cap_event = edge_pick(aux_ctrl_q.capture_edge_select,
                               rise_q[PIN_CAPTURE], fall_q[PIN_CAPTURE]);

  // ----------------------------------------------------------------
  // control registers
  // ----------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aux_ctrl_q <= aux_ctrl_type'(CTRL_RESET);
    end else if (do_write && wsel == SEL_AUX_CTRL) begin
      aux_ctrl_q <= aux_ctrl_type'(merge(aux_ctrl_q, w_data_q, w_strb_q) & AUX_CTRL_MASK);
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      core_ctrl_q <= core_ctrl_type'(CTRL_RESET);
    end else begin
      if (do_write && wsel == SEL_CORE_CTRL) begin
        core_ctrl_q <= core_ctrl_type'(merge(core_ctrl_q, w_data_q, w_strb_q)
                                       & CORE_CTRL_MASK);
        // wrap toggle applied on top of a write
        core_ctrl_q.core_toggle_latch <= w_data_q[10] ^ core_wrap;
        if (!w_strb_q[1]) begin
          core_ctrl_q.core_toggle_latch <= core_ctrl_q.core_toggle_latch ^ core_wrap;
        end
      end else if (core_wrap) begin
        core_ctrl_q.core_toggle_latch <= ~core_ctrl_q.core_toggle_latch;
      end
    end
  end

  // ----------------------------------------------------------------
  // timers and capture/reload register
  // ----------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      core_val_q <= VAL_ZERO;
    end else if (do_write && wsel == SEL_CORE_VAL) begin
      core_val_q <= merge(core_val_q, w_data_q, w_strb_q);
    end else if (core_wrap && core_ctrl_q.reload_enable) begin
      core_val_q <= capture_reload_reg_q;
    end else if (core_step) begin
      core_val_q <= core_down ? core_val_q - 1'b1 : core_val_q + 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aux_val_q <= VAL_ZERO;
    end else if (do_write && wsel == SEL_AUX_VAL) begin
      aux_val_q <= merge(aux_val_q, w_data_q, w_strb_q);
    end else if (cap_event && aux_ctrl_q.clear_on_capture) begin
      aux_val_q <= VAL_ZERO;
    end else if (aux_step) begin
      aux_val_q <= aux_down ? aux_val_q - 1'b1 : aux_val_q + 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      capture_reload_reg_q <= VAL_ZERO;
    end else if (do_write && wsel == SEL_CAPTURE_RELOAD_REG) begin
      capture_reload_reg_q <= merge(capture_reload_reg_q, w_data_q, w_strb_q);
    end else if (cap_event && aux_ctrl_q.capture_enable) begin
      capture_reload_reg_q <= aux_val_q;
    end
  end

  // ----------------------------------------------------------------
  // request flags, write one to clear, set wins
  // ----------------------------------------------------------------
  logic [FLAG_N-1:0] flag_set;
  logic [FLAG_N-1:0] flag_clr;

  // reload sets only the core flag
  assign flag_set[FLAG_CORE]    = core_wrap;
  assign flag_set[FLAG_AUX]     = aux_wrap;
  assign flag_set[FLAG_CAPTURE] = cap_event;
  assign flag_clr = (do_write && wsel == SEL_FLAGS && w_strb_q[0])
                  ? w_data_q[FLAG_N-1:0] : '0;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      flags_q <= '0;
    end else begin
      flags_q <= flag_set | (flags_q & ~flag_clr);
    end
  end

  assign core_irq_flag     = flags_q[FLAG_CORE];
  assign aux_irq_flag      = flags_q[FLAG_AUX];
  assign capture_irq_flag  = flags_q[FLAG_CAPTURE];
  assign core_toggle_latch = core_ctrl_q.core_toggle_latch;

  // ----------------------------------------------------------------
  // axi4-lite write path
  // ----------------------------------------------------------------
  assign s_axi_awready = ~aw_held_q;
  assign s_axi_wready  = ~w_held_q;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_q <= 1'b0;
      aw_addr_q <= '0;
    end else if (s_axi_awvalid && !aw_held_q) begin
      aw_held_q <= 1'b1;
      aw_addr_q <= s_axi_awaddr;
    end else if (do_write) begin
      aw_held_q <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_held_q <= 1'b0;
      w_data_q <= '0;
      w_strb_q <= '0;
    end else if (s_axi_wvalid && !w_held_q) begin
      w_held_q <= 1'b1;
      w_data_q <= s_axi_wdata;
      w_strb_q <= s_axi_wstrb;
    end else if (do_write) begin
      w_held_q <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= RESP_OKAY;
    end else if (do_write) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= (wsel == SEL_NONE) ? RESP_SLVERR : RESP_OKAY;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // axi4-lite read path
  // ----------------------------------------------------------------
  assign s_axi_arready = ~s_axi_rvalid;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= '0;
      s_axi_rresp  <= RESP_OKAY;
    end else if (s_axi_arvalid && !s_axi_rvalid) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp  <= (rsel == SEL_NONE) ? RESP_SLVERR : RESP_OKAY;
      unique case (rsel)
        SEL_AUX_CTRL:  s_axi_rdata <= DATA_W'(aux_ctrl_q);
        SEL_CORE_CTRL: s_axi_rdata <= DATA_W'(core_ctrl_q);
        SEL_AUX_VAL:   s_axi_rdata <= DATA_W'(aux_val_q);
        SEL_CORE_VAL:  s_axi_rdata <= DATA_W'(core_val_q);
        SEL_CAPTURE_RELOAD_REG:    s_axi_rdata <= DATA_W'(capture_reload_reg_q);
        SEL_FLAGS:     s_axi_rdata <= DATA_W'(flags_q);
        SEL_NONE:      s_axi_rdata <= '0;
      endcase
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

endmodule

// ---- shared/aux_timer_pkg.sv ----
package aux_timer_pkg;

  // ----------------------------------------------------------------
  // bus and register map
  // ----------------------------------------------------------------
  localparam int          ADDR_W        = 18;
  localparam int          DATA_W        = 32;
  localparam int          REG_W         = 16;
  localparam int          IDX_W         = 16;
  localparam logic [IDX_W-1:0] AUX_CTRL_IDX  = 16'hff46;
  localparam logic [IDX_W-1:0] CORE_CTRL_IDX = 16'hff48;
  localparam logic [IDX_W-1:0] AUX_VAL_IDX   = 16'hff50;
  localparam logic [IDX_W-1:0] CORE_VAL_IDX  = 16'hff52;
  localparam logic [IDX_W-1:0] CAPTURE_RELOAD_REG_IDX    = 16'hff54;
  localparam logic [IDX_W-1:0] FLAGS_IDX     = 16'hff56;
  localparam logic [1:0]  RESP_OKAY     = 2'h0;
  localparam logic [1:0]  RESP_SLVERR   = 2'h2;

  typedef enum logic [2:0] {
    SEL_NONE      = 3'h0,
    SEL_AUX_CTRL  = 3'h1,
    SEL_CORE_CTRL = 3'h2,
    SEL_AUX_VAL   = 3'h3,
    SEL_CORE_VAL  = 3'h4,
    SEL_CAPTURE_RELOAD_REG    = 3'h5,
    SEL_FLAGS     = 3'h6
  } reg_sel_type;

  // ----------------------------------------------------------------
  // control layouts
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    MODE_TIMER      = 2'h0,
    MODE_COUNTER    = 2'h1,
    MODE_GATED_LOW  = 2'h2,
    MODE_GATED_HIGH = 2'h3
  } mode_type;

  typedef struct packed {
    logic       capture_enable;
    logic       clear_on_capture;
    logic [1:0] capture_edge_select;
    logic [2:0] rsv_hi;
    logic       aux_ext_dir_enable;
    logic       aux_dir_bit;
    logic       aux_run_bit;
    logic       rsv_lo;
    mode_type   aux_mode_field;
    logic [2:0] aux_input_select;
  } aux_ctrl_type;

  typedef struct packed {
    logic       reload_enable;
    logic [3:0] rsv_hi;
    logic       core_toggle_latch;
    logic       rsv_mid;
    logic       core_ext_dir_enable;
    logic       core_dir_bit;
    logic       core_run_bit;
    logic       rsv_lo;
    mode_type   core_mode_field;
    logic [2:0] core_input_select;
  } core_ctrl_type;

  localparam logic [REG_W-1:0] AUX_CTRL_MASK  = 16'hf1df;
  localparam logic [REG_W-1:0] CORE_CTRL_MASK = 16'h85df;
  localparam logic [REG_W-1:0] CTRL_RESET     = 16'h0000;
  localparam logic [REG_W-1:0] VAL_MAX        = 16'hffff;
  localparam logic [REG_W-1:0] VAL_ZERO       = 16'h0000;

  // ----------------------------------------------------------------
  // flags, pins, prescaler
  // ----------------------------------------------------------------
  localparam int FLAG_N       = 3;
  localparam int FLAG_CORE    = 0;
  localparam int FLAG_AUX     = 1;
  localparam int FLAG_CAPTURE = 2;
  localparam int PIN_N        = 5;
  localparam int PIN_CORE_IN  = 0;
  localparam int PIN_CORE_DIR = 1;
  localparam int PIN_AUX_IN   = 2;
  localparam int PIN_AUX_DIR  = 3;
  localparam int PIN_CAPTURE  = 4;
  localparam int PRE_BASE_LOG2 = 2;
  localparam int PRE_W         = 9;

endpackage

// ---- test/aux_timer_properties.sv ----
`timescale 1ns/100ps
module aux_timer_properties (
  // bus
  input wire logic       aclk,
  input wire logic       aresetn,
  input wire logic       s_axi_awvalid,
  input wire logic       s_axi_awready,
  input wire logic       s_axi_bvalid,
  input wire logic       s_axi_bready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic       s_axi_arvalid,
  input wire logic       s_axi_arready,
  input wire logic       s_axi_rvalid,
  input wire logic       s_axi_rready,
  // pins and flags
  input wire logic       capture_input_pin,
  input wire logic       core_irq_flag,
  input wire logic       capture_irq_flag,
  input wire logic       core_toggle_latch
);
  // ------------------------------
  // capture pin age
  // ------------------------------
  logic       pin_q;
  logic [3:0] since_cap_q;
  always_ff @(posedge aclk) pin_q <= capture_input_pin;
  always_ff @(posedge aclk) begin
    if (!aresetn) since_cap_q <= 4'hf;
    else if (capture_input_pin != pin_q) since_cap_q <= 4'h0;
    else if (since_cap_q != 4'hf) since_cap_q <= since_cap_q + 4'h1;
  end
  // ------------------------------
  // properties
  // ------------------------------
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence s_ar_take; s_axi_arvalid && s_axi_arready; endsequence
  sequence s_flag_drop; $fell(core_irq_flag) || $fell(capture_irq_flag); endsequence
  property p_read_answer; s_ar_take |=> s_axi_rvalid; endproperty
  property p_read_hold; s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid; endproperty
  property p_write_hold;
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
  endproperty
  property p_aw_busy; s_axi_awvalid && s_axi_awready |=> !s_axi_awready; endproperty
  property p_resp_code; s_axi_bvalid |-> s_axi_bresp == 2'h0 || s_axi_bresp == 2'h2; endproperty
  property p_wrap_toggle; $rose(core_irq_flag) |-> $changed(core_toggle_latch); endproperty
  property p_cap_cause; $rose(capture_irq_flag) |-> since_cap_q <= 4'ha; endproperty
  property p_flag_clear; s_flag_drop |-> $rose(s_axi_bvalid); endproperty
  a_read_answer: assert property (p_read_answer)
    else $error("read answer missing");
  a_read_hold: assert property (p_read_hold)
    else $error("read answer dropped");
  a_write_hold: assert property (p_write_hold)
    else $error("write answer dropped");
  a_aw_busy: assert property (p_aw_busy)
    else $error("address ready while busy");
  a_resp_code: assert property (p_resp_code)
    else $error("bad write response code");
  a_wrap_toggle: assert property (p_wrap_toggle)
    else $error("core flag without latch toggle");
  a_cap_cause: assert property (p_cap_cause)
    else $error("capture flag without pin edge");
  a_flag_clear: assert property (p_flag_clear)
    else $error("flag dropped without write");
endmodule
bind aux_timer_capture_reload aux_timer_properties u_props (.*);

// ---- test/tb_aux_timer_capture_reload.sv ----
`timescale 1ns/100ps
module tb_aux_timer_capture_reload;
  import aux_timer_pkg::*;
  // ------------------------------
  // signals and bus tasks
  // ------------------------------
  logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [ADDR_W-1:0] s_axi_awaddr, s_axi_araddr;
  logic [DATA_W-1:0] s_axi_wdata, s_axi_rdata;
  logic [3:0]        s_axi_wstrb = 4'h3;
  logic [2:0]        s_axi_awprot = 3'h0, s_axi_arprot = 3'h0;
  logic [1:0]        s_axi_bresp, s_axi_rresp, resp;
  logic core_count_pin = 1'b0, core_dir_pin = 1'b0, aux_count_pin, aux_dir_pin;
  logic capture_input_pin, core_irq_flag, aux_irq_flag, capture_irq_flag, core_toggle_latch;
  logic [15:0] rv;
  int err_count, num_checks, rise_n, fall_n, n;
  localparam logic [17:0] A_AUX = {AUX_CTRL_IDX, 2'h0}, A_CORE = {CORE_CTRL_IDX, 2'h0};
  localparam logic [17:0] A_AV = {AUX_VAL_IDX, 2'h0}, A_CV = {CORE_VAL_IDX, 2'h0};
  localparam logic [17:0] A_CAP = {CAPTURE_RELOAD_REG_IDX, 2'h0}, A_FLG = {FLAGS_IDX, 2'h0};
  aux_timer_capture_reload DUT (.*);
  initial begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end
  always @(posedge core_toggle_latch) rise_n++;
  always @(negedge core_toggle_latch) fall_n++;
  initial begin
    repeat (20000) @(posedge aclk);
    err_count++;
    end_of_test();
  end
  task automatic chk(input string s, input logic [31:0] lo, hi, g);
    num_checks++;
    if ((g >= lo && g <= hi) !== 1'b1) begin
      err_count++;
      $display("ERROR %s expected %0h..%0h seen %0h", s, lo, hi, g);
    end
  endtask
  task automatic tick(input int c);
    repeat (c) @(posedge aclk);
  endtask
  task automatic wr(input logic [17:0] a, input logic [15:0] d);
    s_axi_awaddr <= a;
    s_axi_wdata <= {16'h0, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    resp = s_axi_bresp;
  endtask
  task automatic rd(input logic [17:0] a, output logic [15:0] d);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    d = s_axi_rdata[15:0];
    resp = s_axi_rresp;
  endtask
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  // ------------------------------
  // scenarios
  // ------------------------------
  task automatic t_regs;
    rd(A_AUX, rv);
    chk("aux ctrl reset", CTRL_RESET, CTRL_RESET, rv);
    wr(A_AUX, 16'hffff);
    rd(A_AUX, rv);
    chk("aux ctrl mask", AUX_CTRL_MASK, AUX_CTRL_MASK, rv);
    wr(A_AUX, 16'h0);
    wr(18'h3fd00, 16'h1);
    chk("bad write resp", RESP_SLVERR, RESP_SLVERR, resp);
    rd(18'h3fd04, rv);
    chk("bad read resp", RESP_SLVERR, RESP_SLVERR, resp);
    wr(A_AV, 16'hfffe);
    wr(A_AUX, 16'h0040);
    tick(20);
    wr(A_AUX, 16'h0);
    chk("aux wrap flag", 1, 1, aux_irq_flag);
    wr(A_FLG, 16'h0007);
    chk("aux flag clear", 0, 0, aux_irq_flag);
  endtask
  task automatic t_modes;
    aux_count_pin <= 1'b1;
    for (int m = 0; m < 4; m++) begin
      wr(A_AV, 16'h0100);
      wr(A_AUX, 16'h01c0 | 16'(m << 3));
      tick(40);
      wr(A_AUX, 16'h0);
      rd(A_AV, rv);
      n = (m == 0 || m == 3) ? 12 : 0;
      chk("mode count", 256 - n, 256 - n + (n > 0 ? 3 : 0), rv);
    end
    tick(20);
    rd(A_AV, rv);
    chk("stopped hold", 256 - 12, 256 - 9, rv);
    wr(A_AV, 16'h0);
    wr(A_AUX, 16'h0047);
    tick(1030);
    wr(A_AUX, 16'h0);
    rd(A_AV, rv);
    chk("slow prescale", 2, 3, rv);
  endtask
  task automatic t_chain;
    wr(A_AV, 16'h0);
    wr(A_AUX, 16'h004f);
    wr(A_CORE, 16'h0400);
    tick(10);
    rd(A_AV, rv);
    chk("soft toggle", 0, 0, rv);
    wr(A_AUX, 16'h0);
    wr(A_CAP, 16'h0008);
    wr(A_CORE, 16'h84c0);
    for (int s = 5; s < 8; s++) begin
      wr(A_AV, 16'h0);
      wr(A_AUX, 16'h0048 | 16'(s));
      rise_n = 0;
      fall_n = 0;
      tick(300);
      wr(A_AUX, 16'h0);
      n = (s == 5) ? rise_n : (s == 6) ? fall_n : rise_n + fall_n;
      chk("core wraps", 7, 10, rise_n + fall_n);
      rd(A_AV, rv);
      chk("chain count", n, n, rv);
    end
    rd(A_CV, rv);
    chk("core reload", 0, 8, rv);
    rd(A_FLG, rv);
    chk("wrap flags", 1, 1, {rv[2], rv[0]});
    wr(A_CORE, 16'h8000);
  endtask
  task automatic t_cap;
    for (int c = 0; c < 4; c++) begin
      wr(A_AUX, 16'h0040 | 16'(c << 12));
      for (int e = 0; e < 2; e++) begin
        wr(A_FLG, 16'h0007);
        capture_input_pin <= ~capture_input_pin;
        tick(10);
        rd(A_FLG, rv);
        chk("capture flag", e ? c / 2 : c % 2, e ? c / 2 : c % 2, rv[2]);
      end
    end
    wr(A_AV, 16'h0);
    wr(A_AUX, 16'hd040);
    tick(60);
    capture_input_pin <= 1'b1;
    tick(10);
    rd(A_CAP, rv);
    chk("captured value", 14, 19, rv);
    rd(A_AV, rv);
    chk("cleared timer", 0, 6, rv);
    wr(A_AUX, 16'h5040);
    wr(A_CAP, 16'h5555);
    capture_input_pin <= 1'b0;
    tick(30);
    capture_input_pin <= 1'b1;
    tick(10);
    rd(A_CAP, rv);
    chk("capture off", 16'h5555, 16'h5555, rv);
    rd(A_AV, rv);
    chk("clear without capture", 0, 6, rv);
  endtask
  initial begin
    {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} <= '0;
    {aux_count_pin, aux_dir_pin, capture_input_pin} <= '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} <= '0;
    tick(20);
    aresetn <= 1'b1;
    tick(2);
    t_regs();
    t_modes();
    t_chain();
    t_cap();
    end_of_test();
  end
endmodule
